// ### hw/esf_frame.sv
// encoder side reply framer with memory access and check byte generation
//
// Behaviour
// - position request: echo, status, three bytes, check
// - position low byte first, high byte third
// - position right aligned, upper bits zero
// - address field: index bits 7..1, flag bit 0
// - reads echo address; busy read returns zero
// - idle write accepted, address and data echoed
// - busy write flagged, echoed, discarded
// - memory data field is one byte
// - check byte uses x^8 plus one
// - field bits enter check lsb first
// - check covers every byte before it
// - not ready forces position zero, flag set
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "esf_consts.svh"
`default_nettype none

module esf_frame
  import esf_pkg::*;
#(
  parameter int unsigned WR_CNT_W     = 20,
  parameter int unsigned WRITE_CYCLES = `ESF_MEM_WRITE_MS * `ESF_CLK_KHZ
) (
  input  wire logic        mclk_i,             // system clock, 40 MHz
  input  wire logic        arst_n_i,           // asynchronous reset, active low
  input  wire logic        ce_i,               // clock enable, freezes all state
  // decoded request from the link receiver
  input  wire logic        req_valid_i,        // request present
  output logic             req_ready_o,        // framer idle, request taken
  input  wire logic [7:0]  req_cf_i,           // control field as received
  input  wire logic [3:0]  req_id_i,           // data identifier
  input  wire logic [7:0]  req_adf_i,          // address field of request
  input  wire logic [7:0]  req_edf_i,          // data field of request
  // reply byte stream towards the link transmitter
  output logic             tx_valid_o,         // reply byte present
  input  wire logic        tx_ready_i,         // transmitter takes byte
  output logic [7:0]       tx_data_o,          // reply byte
  output logic             tx_last_o,          // byte is the check byte
  // position source and readiness pin
  input  wire logic [23:0] pos_i,              // raw singleturn position
  input  wire logic        not_ready_pin_i,    // asynchronous not-ready level
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o               // level interrupt
);

  // ---------------------------------------------------------------- state
  esf_state_t  st_ff;                  // sequencer state
  logic [7:0]  frame_ff [1:4];         // payload bytes after the echo
  logic [2:0]  len_ff;                 // echo and payload bytes before check byte
  logic [2:0]  idx_ff;                 // index of byte now on tx_data_o
  logic [7:0]  tx_data_ff;             // byte now offered
  logic        last_ff;                // offered byte is the check byte
  logic [7:0]  crc_ff;                 // check register over sent bytes
  logic [7:0]  mem_ff [0:127];         // byte memory, flip-flops
  logic [WR_CNT_W-1:0] wr_cnt_ff;      // remaining write busy cycles
  logic        nr_s1_ff;               // pin synchroniser, first stage
  logic        nr_s2_ff;               // pin synchroniser, second stage
  logic [2:0]  ctrl_ff;                // resolution and hold bit
  logic [3:0]  irq_stat_ff;            // sticky events
  logic [3:0]  irq_mask_ff;            // event enables
  logic        ack_ff;                 // bus answer cycle
  logic [31:0] rdata_ff;               // bus read data

  // ---------------------------------------------------------------- check step
  // one byte through the x^8+1 register, bit 0 first
  function automatic logic [7:0] esf_crc_byte(input logic [7:0] crc,
                                              input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int b = 0; b < 8; b++) begin
      c = {c[6:0], data[b] ^ c[7]};
    end
    return c;
  endfunction

  // ---------------------------------------------------------------- readiness
  // readiness is either the synchronised pin or a software hold
  wire        not_ready_w = nr_s2_ff | ctrl_ff[`ESF_CTRL_HOLD_BIT];
  wire [1:0]  res_w       = ctrl_ff[`ESF_CTRL_RES_LSB +: 2];

  // spare code falls back to the widest mask
  wire [23:0] res_mask_w  = (res_w == ESF_RES_21) ? `ESF_MASK_21 :
                            (res_w == ESF_RES_17) ? `ESF_MASK_17 :
                            `ESF_MASK_23;
  wire [23:0] pos_eff_w   = not_ready_w ? 24'h000000
                                        : (pos_i & res_mask_w);
  wire [7:0]  sf_w        = not_ready_w ? `ESF_SF_NOT_READY
                                        : `ESF_SF_READY;

  // ---------------------------------------------------------------- decode
  wire        take_w   = ce_i & req_valid_i & (st_ff == ESF_IDLE);
  wire        is_pos_w = (req_id_i == `ESF_ID_POS);
  wire        is_rd_w  = (req_id_i == `ESF_ID_MEM_READ);
  wire        is_wr_w  = (req_id_i == `ESF_ID_MEM_WRITE);
  wire        busy_w   = (wr_cnt_ff != '0);
  wire [6:0]  mem_idx_w = req_adf_i[7:1];
  wire [7:0]  mem_rd_w  = mem_ff[mem_idx_w];
  // the incoming flag bit is ignored, our own flag replaces it
  wire [7:0]  adf_echo_w = {mem_idx_w, busy_w};
  wire [7:0]  rd_byte_w  = busy_w ? 8'h00 : mem_rd_w;
  wire        wr_ok_w    = take_w & is_wr_w & ~busy_w;
  wire        wr_drop_w  = take_w & is_wr_w & busy_w;
  wire        rd_bad_w   = take_w & is_rd_w & busy_w;

  // payload bytes: status or address, then data
  wire [7:0]  f1_w = (is_rd_w | is_wr_w) ? adf_echo_w : sf_w;
  wire [7:0]  f2_w = is_pos_w ? pos_eff_w[7:0] :
                     is_rd_w  ? rd_byte_w      :
                     req_edf_i;
  wire [2:0]  len_w = is_pos_w               ? `ESF_LEN_POS :
                      (is_rd_w | is_wr_w)    ? `ESF_LEN_MEM :
                      `ESF_LEN_OTHER;

  // ---------------------------------------------------------------- transmit
  wire        hs_w      = ce_i & tx_valid_o & tx_ready_i;
  wire [7:0]  crc_nxt_w = esf_crc_byte(crc_ff, tx_data_ff);
  wire [2:0]  idx_nxt_w = idx_ff + 3'h1;
  wire        at_end_w  = (idx_nxt_w == len_ff);
  // guard keeps the index inside the payload array
  wire [7:0]  nxt_byte_w = (idx_nxt_w == 3'h1) ? frame_ff[1] :
                           (idx_nxt_w == 3'h2) ? frame_ff[2] :
                           (idx_nxt_w == 3'h3) ? frame_ff[3] :
                           frame_ff[4];

  assign req_ready_o = (st_ff == ESF_IDLE);
  assign tx_valid_o  = (st_ff == ESF_SEND);
  assign tx_data_o   = tx_data_ff;
  assign tx_last_o   = last_ff;

  // sequencer: load a frame, then walk it out and append the check byte
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff      <= ESF_IDLE;
      len_ff     <= 3'h0;
      idx_ff     <= 3'h0;
      tx_data_ff <= 8'h00;
      last_ff    <= 1'b0;
      crc_ff     <= 8'h00;
    end else if (take_w) begin
      st_ff      <= ESF_SEND;
      len_ff     <= len_w;
      idx_ff     <= 3'h0;
      tx_data_ff <= req_cf_i;          // echo control field first
      last_ff    <= 1'b0;
      crc_ff     <= 8'h00;
    end else if (hs_w) begin
      if (last_ff) begin
        st_ff <= ESF_IDLE;             // check byte gone, frame done
      end else begin
        crc_ff <= crc_nxt_w;
        idx_ff <= idx_nxt_w;
        if (at_end_w) begin
          tx_data_ff <= crc_nxt_w;
          last_ff    <= 1'b1;
        end else begin
          tx_data_ff <= nxt_byte_w;
        end
      end
    end
  end

  // payload capture; no reset needed, bytes are loaded before use
  always_ff @(posedge mclk_i) begin
    if (take_w) begin
      frame_ff[1] <= f1_w;
      frame_ff[2] <= f2_w;
      frame_ff[3] <= pos_eff_w[15:8];
      frame_ff[4] <= pos_eff_w[23:16];
    end
  end

  // ---------------------------------------------------------------- memory
  // storage takes the byte at once; the busy window models the slow write
  always_ff @(posedge mclk_i) begin
    if (wr_ok_w) begin
      mem_ff[mem_idx_w] <= req_edf_i;
    end
  end

  // write busy counter; a write inside the window is dropped
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_cnt_ff <= '0;
    end else if (ce_i) begin
      if (wr_ok_w) begin
        wr_cnt_ff <= WR_CNT_W'(WRITE_CYCLES);
      end else if (busy_w) begin
        wr_cnt_ff <= wr_cnt_ff - WR_CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------- pin sync
  // the first stage feeds only the second, never the logic
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nr_s1_ff <= 1'b1;
      nr_s2_ff <= 1'b1;
    end else if (ce_i) begin
      nr_s1_ff <= not_ready_pin_i;
      nr_s2_ff <= nr_s1_ff;
    end
  end

  // ---------------------------------------------------------------- bus
  // one wait cycle on every access keeps read data registered
  wire        acc_w    = avs_read_i | avs_write_i;
  wire        bus_wr_w = ce_i & avs_write_i & ack_ff & avs_byteenable_i[0];
  wire        sel_ctrl_w = (avs_address_i == `ESF_OFF_CTRL);
  wire        sel_stat_w = (avs_address_i == `ESF_OFF_STATUS);
  wire        sel_irqs_w = (avs_address_i == `ESF_OFF_IRQ_STAT);
  wire        sel_irqm_w = (avs_address_i == `ESF_OFF_IRQ_MASK);
  wire [31:0] rd_mux_w =
    sel_ctrl_w ? {29'h0, ctrl_ff} :
    sel_stat_w ? {28'h0, not_ready_w, busy_w, ~req_ready_o, 1'b0} :
    sel_irqs_w ? {28'h0, irq_stat_ff} :
    sel_irqm_w ? {28'h0, irq_mask_ff} :
    32'h0;                             // unmapped reads as zero
  wire [3:0]  ev_w = {rd_bad_w, wr_drop_w, wr_ok_w, hs_w & last_ff};
  wire [3:0]  w1c_w = (bus_wr_w && sel_irqs_w) ? avs_writedata_i[3:0] : 4'h0;

  assign avs_waitrequest_o = acc_w & ~ack_ff;
  assign avs_readdata_o    = rdata_ff;
  assign irq_o             = |(irq_stat_ff & irq_mask_ff);

  // answer timing and read data capture
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else if (ce_i) begin
      ack_ff <= acc_w & ~ack_ff;
      if (avs_read_i && !ack_ff) begin
        rdata_ff <= rd_mux_w;
      end
    end
  end

  // software registers; an event in the clear cycle stays set
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff     <= `ESF_CTRL_RST;
      irq_stat_ff <= `ESF_IRQ_RST;
      irq_mask_ff <= `ESF_IRQ_RST;
    end else if (ce_i) begin
      irq_stat_ff <= (irq_stat_ff & ~w1c_w) | ev_w;
      if (bus_wr_w && sel_ctrl_w) begin
        ctrl_ff <= avs_writedata_i[2:0];
      end
      if (bus_wr_w && sel_irqm_w) begin
        irq_mask_ff <= avs_writedata_i[3:0];
      end
    end
  end

  // ---------------------------------------------------------------- checks
  default clocking esf_cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i || !ce_i);

  // bit reversal used to check the byte step independently
  function automatic logic [7:0] esf_rev(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 0; b < 8; b++) begin
      r[7-b] = d[b];
    end
    return r;
  endfunction

  a_pos_frame_len: assert property (
    take_w && is_pos_w |=> len_ff == 3'h5 && tx_data_o == $past(req_cf_i)
  ) else $error("position reply has wrong length or echo");

  a_pos_byte_order: assert property (
    take_w && is_pos_w |=> frame_ff[2] == $past(pos_eff_w[7:0]) &&
                           frame_ff[4] == $past(pos_eff_w[23:16])
  ) else $error("position bytes out of order");

  a_pos_align_17: assert property (
    res_w == ESF_RES_17 |-> pos_eff_w[23:17] == 7'h00
  ) else $error("position not right aligned at 17 bits");

  a_read_busy_zero: assert property (
    take_w && is_rd_w && busy_w |=> frame_ff[2] == 8'h00 && frame_ff[1][0]
  ) else $error("busy read did not return zero with flag");

  a_write_accept: assert property (
    wr_ok_w |=> busy_w && !frame_ff[1][0] && frame_ff[2] == $past(req_edf_i)
  ) else $error("accepted write not echoed or not busy");

  a_write_drop: assert property (
    wr_drop_w |=> frame_ff[1][0] && mem_ff[$past(mem_idx_w)] == $past(mem_rd_w)
  ) else $error("dropped write changed memory");

  // the first step is judged on the handshake of the echo byte itself
  a_crc_start: assert property (
    take_w |=> crc_ff == 8'h00 ##1 (!$past(hs_w) ||
                                    crc_ff == esf_rev($past(tx_data_ff)))
  ) else $error("check register did not start at zero");

  a_crc_step: assert property (
    hs_w && !last_ff |=> crc_ff == ($past(crc_ff) ^ esf_rev($past(tx_data_ff)))
  ) else $error("check step wrong");

  a_not_ready_zero: assert property (
    take_w && is_pos_w && not_ready_w |=> frame_ff[2] == 8'h00 &&
                                          frame_ff[3] == 8'h00 &&
                                          frame_ff[1] == `ESF_SF_NOT_READY
  ) else $error("position not forced to zero while not ready");

  a_pos_align_21: assert property (
    res_w == ESF_RES_21 |-> pos_eff_w[23:21] == 3'h0
  ) else $error("position not right aligned at 21 bits");

  a_pos_align_23: assert property (
    res_w == ESF_RES_23 |-> pos_eff_w[23] == 1'b0
  ) else $error("position not right aligned at 23 bits");

  a_addr_echo: assert property (
    take_w && (is_rd_w || is_wr_w) |=> frame_ff[1][7:1] == $past(req_adf_i[7:1])
  ) else $error("address field index not echoed");

  a_read_idle_data: assert property (
    take_w && is_rd_w && !busy_w |=> frame_ff[2] == $past(mem_rd_w) && !frame_ff[1][0]
  ) else $error("idle read did not return stored byte");

  a_write_store: assert property (
    wr_ok_w |=> mem_ff[$past(mem_idx_w)] == $past(req_edf_i)
  ) else $error("accepted write not stored");

  // the byte after the last payload byte must be the running check value
  a_chk_last: assert property (
    hs_w && !last_ff && at_end_w |=> tx_last_o && tx_data_o == crc_ff
  ) else $error("check byte not appended after payload");

endmodule // esf_frame

`default_nettype wire

// ### pkg/esf_consts.svh
// constants of the encoder serial frame block: offsets, fields, codes, timing
`ifndef ESF_CONSTS_SVH
`define ESF_CONSTS_SVH

// register byte offsets on the avalon slave
`define ESF_OFF_CTRL      5'h00
`define ESF_OFF_STATUS    5'h04
`define ESF_OFF_IRQ_STAT  5'h08
`define ESF_OFF_IRQ_MASK  5'h0c

// control register fields and reset value
`define ESF_CTRL_RES_LSB  0
`define ESF_CTRL_HOLD_BIT 2
`define ESF_CTRL_RST      3'h0

// interrupt event bit positions
`define ESF_IRQ_FRAME     0
`define ESF_IRQ_WR_OK     1
`define ESF_IRQ_WR_DROP   2
`define ESF_IRQ_RD_BAD    3
`define ESF_IRQ_RST       4'h0

// data identifiers of requests
`define ESF_ID_POS        4'h0
`define ESF_ID_MEM_READ   4'hd
`define ESF_ID_MEM_WRITE  4'h6

// status field values while not ready and while ready
`define ESF_SF_NOT_READY  8'h02
`define ESF_SF_READY      8'h00

// position masks per resolution
`define ESF_MASK_23       24'h7fffff
`define ESF_MASK_21       24'h1fffff
`define ESF_MASK_17       24'h01ffff

// echo and payload byte counts before the check byte
`define ESF_LEN_POS       3'h5
`define ESF_LEN_MEM       3'h3
`define ESF_LEN_OTHER     3'h2

// memory write busy time, clock rate
`define ESF_MEM_WRITE_MS  18
`define ESF_CLK_KHZ       40000

`endif

// ### pkg/esf_pkg.sv
// types of the encoder serial frame block
package esf_pkg;

  // frame sequencer states
  typedef enum logic [0:0] {
    ESF_IDLE,
    ESF_SEND
  } esf_state_t;

  // position resolution select
  typedef enum logic [1:0] {
    ESF_RES_23,
    ESF_RES_21,
    ESF_RES_17,
    ESF_RES_SPARE
  } esf_res_t;

endpackage

// ### testbench/esf_master_model.sv
// far-side master model: issues requests and takes reply bytes with stalls
`timescale 1ns/100ps
`default_nettype none

module esf_master_model (
  input  wire logic       clk_i,        // system clock
  input  wire logic       req_ready_i,  // framer idle
  output logic            req_valid_o,  // request present
  output logic [7:0]      cf_o,         // control field
  output logic [3:0]      id_o,         // data identifier
  output logic [7:0]      adf_o,        // address field
  output logic [7:0]      edf_o,        // data field
  output logic            tx_ready_o    // reply byte taken
);
  initial begin
    req_valid_o = 1'b0;
    cf_o = 8'h00;
    id_o = 4'h0;
    adf_o = 8'h00;
    edf_o = 8'h00;
  end

  // random stalls: the link side is not always ready for the next byte
  always @(posedge clk_i) begin
    tx_ready_o <= ($urandom_range(3) != 0);
  end

  // one request, held until the framer takes it
  task automatic send(input logic [7:0] cf, input logic [3:0] id,
                      input logic [7:0] adf, input logic [7:0] edf, output bit ok);
    int n;
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    cf_o <= cf;
    id_o <= id;
    adf_o <= {adf[7:1], 1'b0};
    edf_o <= edf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_i !== 1'b1 && n < 400);
    ok = (n < 400);
    req_valid_o <= 1'b0;
    // released cf, adf and edf fields show inverted values so stale data cannot pass
    cf_o <= ~cf;
    adf_o <= ~adf;
    edf_o <= ~edf;
  endtask
endmodule // esf_master_model

`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the encoder reply framer
`timescale 1ns/100ps
`include "esf_consts.svh"
`default_nettype none

module tb_top;
  logic        mclk = 1'b0;       // 40 MHz clock
  logic        arst_n = 1'b0;     // reset, active low
  logic        nrdy = 1'b0;       // not-ready pin
  logic        rd = 1'b0;         // bus read
  logic        wr = 1'b0;         // bus write
  logic [4:0]  addr = 5'h00;      // bus address
  logic [31:0] wdata = 32'h0;     // bus write data
  logic [3:0]  be = 4'hf;         // bus byte enables
  logic [23:0] pos = 24'h0;       // raw position
  logic [31:0] rdata;
  logic [7:0]  cf, adf, edf, tx_data;
  logic [3:0]  id;
  logic        req_valid, req_ready, tx_valid, tx_ready, tx_last, waitreq, irq;
  logic [8:0]  exp_q[$];          // expected {last, byte}
  logic [7:0]  fb[$];             // reply bytes after the echo
  int          err_total = 0;
  int          compares = 0;

  esf_frame #(.WRITE_CYCLES(200)) dut_u (
    .mclk_i(mclk), .arst_n_i(arst_n), .ce_i(1'b1), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_cf_i(cf), .req_id_i(id), .req_adf_i(adf),
    .req_edf_i(edf), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
    .tx_last_o(tx_last), .pos_i(pos), .not_ready_pin_i(nrdy), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq));

  esf_master_model mdl (
    .clk_i(mclk), .req_ready_i(req_ready), .req_valid_o(req_valid), .cf_o(cf),
    .id_o(id), .adf_o(adf), .edf_o(edf), .tx_ready_o(tx_ready));

  // clock toggles every half period
  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // serial check register, one bit at a time, lsb of the byte first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int k = 0; k < 8; k++) c = {c[6:0], b[k] ^ c[7]};
    return c;
  endfunction

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("FAIL %0t bus answer timeout", $time);
      close_out();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // queue a whole reply with its check byte, send request, wait for drain
  task automatic run(input logic [3:0] i, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] c;
    logic [7:0] f;
    bit         ok;
    int         n;
    f = 8'($urandom);
    c = 8'h00;
    fb.push_front(f);
    foreach (fb[k]) begin
      c = crc8(c, fb[k]);
      exp_q.push_back({1'b0, fb[k]});
    end
    exp_q.push_back({1'b1, c});
    fb.delete();
    mdl.send(f, i, a, d, ok);
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    if (!ok || n >= 500) begin
      err_total++;
      $display("FAIL %0t reply timeout", $time);
      close_out();
    end
  endtask

  // watcher: every reply byte handed over is matched with the oldest note
  always @(posedge mclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("FAIL %0t unexpected byte", $time);
      end else begin
        chk({23'h0, tx_last, tx_data}, {23'h0, exp_q.pop_front()});
      end
    end
  end

  initial begin
    logic [31:0] q, m, p, v;
    logic [6:0]  ix;
    logic [7:0]  dv;
    void'($urandom(32'he511fb12));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(`ESF_OFF_CTRL, 32'h0);
    rchk(`ESF_OFF_IRQ_STAT, 32'h0);
    rchk(`ESF_OFF_IRQ_MASK, 32'h0);
    rchk(5'h10, 32'h0);
    rchk(`ESF_OFF_STATUS, 32'h0);
    // a write without its low byte lane must leave the register alone
    be <= 4'he;
    bus(1'b1, `ESF_OFF_CTRL, 32'h7, q);
    be <= 4'hf;
    rchk(`ESF_OFF_CTRL, 32'h0);
    $display("test registers done");
    // every resolution setting, spare code reads as 23 bits
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, `ESF_OFF_CTRL, 32'(r), q);
      m = (r == 1) ? `ESF_MASK_21 : (r == 2) ? `ESF_MASK_17 : `ESF_MASK_23;
      p = $urandom;
      pos <= p[23:0];
      v = p & m;
      fb = '{`ESF_SF_READY, v[7:0], v[15:8], v[23:16]};
      run(`ESF_ID_POS, 8'h00, 8'h00);
    end
    $display("test position done");
    nrdy <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(`ESF_OFF_STATUS, 32'h8);
    fb = '{`ESF_SF_NOT_READY, 8'h00, 8'h00, 8'h00};
    run(`ESF_ID_POS, 8'h00, 8'h00);
    nrdy <= 1'b0;
    // software hold gives the same not-ready reply with the pin released
    bus(1'b1, `ESF_OFF_CTRL, 32'h4, q);
    fb = '{`ESF_SF_NOT_READY, 8'h00, 8'h00, 8'h00};
    run(`ESF_ID_POS, 8'h00, 8'h00);
    bus(1'b1, `ESF_OFF_CTRL, 32'h0, q);
    repeat (4) @(posedge mclk);
    fb = '{`ESF_SF_READY};
    run(4'h3, 8'h00, 8'h00);
    $display("test not ready done");
    // accepted write, busy read, dropped write, then read back after busy
    ix = 7'($urandom);
    dv = 8'($urandom);
    fb = '{{ix, 1'b0}, dv};
    run(`ESF_ID_MEM_WRITE, {ix, 1'b0}, dv);
    rchk(`ESF_OFF_STATUS, 32'h4);
    fb = '{{ix, 1'b1}, 8'h00};
    run(`ESF_ID_MEM_READ, {ix, 1'b0}, 8'h00);
    fb = '{{ix, 1'b1}, ~dv};
    run(`ESF_ID_MEM_WRITE, {ix, 1'b0}, ~dv);
    repeat (250) @(posedge mclk);
    fb = '{{ix, 1'b0}, dv};
    run(`ESF_ID_MEM_READ, {ix, 1'b0}, 8'h00);
    $display("test memory done");
    // all four events latched; mask one, clear it, others stay
    rchk(`ESF_OFF_IRQ_STAT, 32'hf);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `ESF_OFF_IRQ_MASK, 32'h4, q);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `ESF_OFF_IRQ_STAT, 32'h4, q);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rchk(`ESF_OFF_IRQ_STAT, 32'hb);
    $display("test interrupt done");
    close_out();
  end
endmodule // tb_top

`default_nettype wire
